// [dv/hw_monitor_pins_test.sv]
module hw_monitor_pins_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0, lclk = 1'b0, rst = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
   logic wr = 1'b0, rd = 1'b0;
   logic valid, ready, active;
   logic [2:0] ch, dev_addr;
   logic [7:0] sdata;
   logic alert_n = 1'b1, latch = 1'b0, test_n = 1'b1;
   logic a0_pin = 1'b1, a0_out, a0_oe_n;
   logic [1:0] upper = 2'h2;
   logic [1:0] fan = 2'h0;
   logic cs_o, cs_oe_n, int_o, int_oe_n, pw_o, pw_oe_n, rs_o, rs_oe_n;
   wire logic case_line, a0_line;
   int num_errors = 0, comparisons = 0, case_len = 0, rst_len = 0;
   bit ok;

   always #5 clk = ~clk;
   initial #3 forever #7.5 lclk = ~lclk;

   assign case_line = cs_oe_n ? latch : 1'b0;
   assign a0_line = a0_oe_n ? a0_pin : a0_out;

   always @(posedge clk) begin
      if (cs_oe_n === 1'b0) case_len <= case_len + 1;
      if (rs_oe_n === 1'b0) rst_len <= rst_len + 1;
   end

   hw_monitor_pins #(.CLR_PULSE_CYC(20'h00014), .RST_PULSE_CYC(20'h00014))
   dut (
      .CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .LINK_CLK_I(lclk), .SAMPLE_VALID_I(valid),
      .SAMPLE_CH_I(ch), .SAMPLE_DATA_I(sdata), .SAMPLE_READY_O(ready),
      .MONITOR_ACTIVE_O(active), .FAN_TACH_INPUTS_I(fan),
      .BOARD_TEMP_ALERT_IN_N_I(alert_n), .CASE_OPEN_LINE_I(case_line),
      .CASE_OPEN_LINE_O(cs_o), .CASE_OPEN_LINE_OE_N_O(cs_oe_n),
      .INT_O(int_o), .INT_OE_N_O(int_oe_n), .POWER_SWITCH_OUT_O(pw_o),
      .POWER_SWITCH_OUT_OE_N_O(pw_oe_n),
      .CONNECTIVITY_TEST_IN_N_I(test_n),
      .MASTER_RESET_OR_OVERTEMP_OUT_O(rs_o),
      .MASTER_RESET_OR_OVERTEMP_OUT_OE_N_O(rs_oe_n),
      .ADDR_LSB_TEST_OUT_I(a0_line), .ADDR_LSB_TEST_OUT_O(a0_out),
      .ADDR_LSB_TEST_OUT_OE_N_O(a0_oe_n), .ADDR_UPPER_PINS_I(upper),
      .DEV_ADDR_LOW_O(dev_addr)
   );

   link_src src (
      .clk_i(lclk), .ready_i(ready), .valid_o(valid), .ch_o(ch),
      .data_o(sdata)
   );

   task automatic end_sim();
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      rreg(hwmon_pkg::ADDR_CFG, rv);
      check(rv, hwmon_pkg::CFG_RST);
      rreg(hwmon_pkg::ADDR_TEMP_LIM, rv);
      check(rv, 8'h7F);
      rreg(8'h14, rv);
      check(rv, 8'hFF);
      rreg(8'h40, rv);
      check(rv, 8'h00);
      check({7'h00, int_oe_n}, 8'h01);
      check({5'h00, dev_addr}, 8'h05);
   endtask

   task automatic t_limit();
      wreg(hwmon_pkg::ADDR_CFG, 8'h03);
      wreg(8'h14, 8'h50);
      src.send(3'h2, 8'h5A, ok);
      check({7'h00, ok}, 8'h01);
      for (int n = 0; n < 20 && rv !== 8'h5A; n++) rreg(8'h22, rv);
      check(rv, 8'h5A);
      idle(2);
      check({6'h00, int_oe_n, int_o}, 8'h00);
      rreg(hwmon_pkg::ADDR_ST1, rv);
      check(rv, 8'h04);
      rreg(hwmon_pkg::ADDR_ST1, rv);
      check(rv, 8'h00);
   endtask

   task automatic t_alert();
      alert_n <= 1'b0;
      latch <= 1'b1;
      idle(6);
      alert_n <= 1'b1;
      latch <= 1'b0;
      idle(6);
      rreg(hwmon_pkg::ADDR_ST2, rv);
      check(rv & 8'h12, 8'h12);
      rreg(hwmon_pkg::ADDR_ST2, rv);
      check(rv & 8'h12, 8'h00);
      // open-source style: pin driven high while a flag is set
      wreg(hwmon_pkg::ADDR_CFG, 8'h23);
      #1 check({6'h00, int_oe_n, int_o}, 8'h02);
      alert_n <= 1'b0;
      idle(6);
      check({6'h00, int_oe_n, int_o}, 8'h01);
      alert_n <= 1'b1;
      idle(26);
      rreg(hwmon_pkg::ADDR_ST2, rv);
      check(rv & 8'h02, 8'h02);
   endtask

   task automatic t_pins();
      wreg(hwmon_pkg::ADDR_CFG, 8'h09);
      #1 check({7'h00, pw_oe_n}, 8'h00);
      check({7'h00, pw_o}, 8'h00);
      case_len = 0;
      wreg(hwmon_pkg::ADDR_CFG, 8'h21);
      idle(40);
      check(8'(case_len), 8'h14);
      check({7'h00, case_line}, 8'h00);
      rst_len = 0;
      wreg(hwmon_pkg::ADDR_CFG, 8'h11);
      idle(30);
      check(8'(rst_len), 8'h00);
      wreg(hwmon_pkg::ADDR_FANDIV, 8'h80);
      wreg(hwmon_pkg::ADDR_CFG, 8'h11);
      idle(40);
      check(8'(rst_len), 8'h14);
      // overtemperature: temperature code above its limit pulls pin low
      wreg(hwmon_pkg::ADDR_FANDIV, 8'h40);
      src.send(hwmon_pkg::TEMP_CH, 8'h90, ok);
      for (int n = 0; n < 20 && rv !== 8'h90; n++) rreg(8'h27, rv);
      idle(2);
      check({7'h00, rs_oe_n}, 8'h00);
      wreg(hwmon_pkg::ADDR_FANDIV, 8'h00);
      #1 check({7'h00, rs_oe_n}, 8'h01);
   endtask

   task automatic t_shutdown();
      wreg(hwmon_pkg::ADDR_CFG, 8'h00);
      idle(2);
      check({7'h00, active}, 8'h00);
      src.send(3'h2, 8'h11, ok);
      idle(20);
      rreg(8'h22, rv);
      check(rv, 8'h5A);
   endtask

   task automatic t_tree();
      wreg(hwmon_pkg::ADDR_CFG, 8'h01);
      test_n <= 1'b0;
      idle(6);
      check({7'h00, a0_oe_n}, 8'h00);
      check({7'h00, a0_line}, 8'h01);
      check({5'h00, dev_addr}, 8'h00);
      // a single input change must flip the tree output
      latch <= 1'b1;
      idle(4);
      check({7'h00, a0_line}, 8'h00);
      latch <= 1'b0;
      idle(4);
      test_n <= 1'b1;
      idle(6);
      rreg(hwmon_pkg::ADDR_CFG, rv);
      check(rv, hwmon_pkg::CFG_RST);
      check({7'h00, a0_oe_n}, 8'h01);
   endtask

   // two tach edges about three base ticks apart
   task automatic t_fan();
      wreg(hwmon_pkg::ADDR_FLIM_BASE, 8'h01);
      wreg(hwmon_pkg::ADDR_CFG, 8'h01);
      fan <= 2'h1;
      idle(6000);
      rreg(hwmon_pkg::ADDR_ST2, rv);
      fan <= 2'h0;
      idle(6000);
      fan <= 2'h1;
      idle(6);
      rreg(hwmon_pkg::ADDR_FCNT_BASE, rv);
      check({7'h00, rv >= 8'h02 && rv <= 8'h04}, 8'h01);
      rreg(hwmon_pkg::ADDR_ST2, rv);
      check(rv & 8'h04, 8'h04);
      fan <= 2'h0;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      idle(6);
      t_reset();
      t_limit();
      t_alert();
      t_pins();
      t_shutdown();
      t_tree();
      t_fan();
      end_sim();
   end
endmodule

// [dv/link_src.sv]
module link_src (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [2:0] ch_o,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      valid_o = 1'b0;
      ch_o = 3'h0;
      data_o = 8'h00;
   end

   // offer one word, hold it until ready is seen at an edge, for at most 40 edges
   task automatic send(input logic [2:0] ch, input logic [7:0] d,
                       output bit ok);
      int n;
      @(posedge clk_i);
      valid_o <= 1'b1;
      ch_o <= ch;
      data_o <= d;
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_i);
         if (ready_i === 1'b1) ok = 1'b1;
      end
      // released lines show no stale word
      valid_o <= 1'b0;
      ch_o <= ~ch;
      data_o <= ~d;
   endtask
endmodule

// [hdl/hw_monitor_pins.sv]
// Functional notes
// R1: out-of-limit values assert the interrupt output
// R2: seven voltage inputs each compared to limits
// R3: eight-bit codes, 10 mV step, 2.56 V
// R4: two digital tach inputs, programmable divisors
// R5: external latch shows chassis open high
// R6: config bit 5 pulls case line low 10ms
// R7: config bit 5 picks interrupt output style
// R8: interrupt output driven only with bit 1
// R9: master reset pulse low, at least 10ms
// R10: reset needs config bit 4, divisor bit 7
// R11: divisor bit 6 makes pin overtemp output
// R12: low test input enables NAND tree test
// R13: test mode holds power-on reset state
// R14: lowest address pin outputs tree result
// R15: address pins give low three address bits
// R16: board alert level flagged in status
// R17: software drives power switch low, open-drain
// R18: shutdown mode stops monitoring activity
// R19: status flags stay set until read
module hw_monitor_pins #(
   parameter logic [19:0] CLR_PULSE_CYC = hwmon_pkg::PULSE_MIN_CYC,
   parameter logic [19:0] RST_PULSE_CYC = hwmon_pkg::PULSE_MIN_CYC
) (
   input wire logic CLOCK_I,
   input wire logic SYS_RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic LINK_CLK_I,
   input wire logic SAMPLE_VALID_I,
   input wire logic [2:0] SAMPLE_CH_I,
   input wire logic [7:0] SAMPLE_DATA_I,
   output logic SAMPLE_READY_O,
   output logic MONITOR_ACTIVE_O,
   input wire logic [1:0] FAN_TACH_INPUTS_I,
   input wire logic BOARD_TEMP_ALERT_IN_N_I,
   input wire logic CASE_OPEN_LINE_I,
   output logic CASE_OPEN_LINE_O,
   output logic CASE_OPEN_LINE_OE_N_O,
   output logic INT_O,
   output logic INT_OE_N_O,
   output logic POWER_SWITCH_OUT_O,
   output logic POWER_SWITCH_OUT_OE_N_O,
   input wire logic CONNECTIVITY_TEST_IN_N_I,
   output logic MASTER_RESET_OR_OVERTEMP_OUT_O,
   output logic MASTER_RESET_OR_OVERTEMP_OUT_OE_N_O,
   input wire logic ADDR_LSB_TEST_OUT_I,
   output logic ADDR_LSB_TEST_OUT_O,
   output logic ADDR_LSB_TEST_OUT_OE_N_O,
   input wire logic [1:0] ADDR_UPPER_PINS_I,
   output logic [2:0] DEV_ADDR_LOW_O
);

   typedef struct packed {
      logic [1:0] tst_s;
      logic [1:0] bti_s;
      logic [1:0] ci_s;
      logic [1:0][1:0] fan_s;
      logic [1:0][2:0] addr_s;
      logic [1:0] req_s;
      logic req_seen;
      logic [1:0] fan_prev;
      logic [7:0] cfg;
      logic [7:0] fandiv;
      logic [7:0] temp_lim;
      logic [6:0][7:0] lim_hi;
      logic [6:0][7:0] lim_lo;
      logic [7:0][7:0] val;
      logic [1:0][7:0] fan_cnt;
      logic [1:0][7:0] fan_lim;
      logic [1:0][7:0] fan_acc;
      logic [1:0][7:0] pre_cnt;
      logic [15:0] base_cnt;
      logic [6:0] st1;
      logic [4:0] st2;
      logic ci_clr;
      logic [19:0] ci_cnt;
      logic rst_act;
      logic [19:0] rst_cnt;
      logic [7:0] rdata;
      logic int_o;
      logic int_oe_n;
      logic pwr_oe_n;
      logic ci_oe_n;
      logic ros_oe_n;
      logic a0_o;
      logic a0_oe_n;
      logic [2:0] dev_addr;
   } main_t;

   typedef struct packed {
      logic [1:0] rst_s;
      logic [1:0] ack_s;
      logic req;
      logic [2:0] ch;
      logic [7:0] data;
   } link_t;

   main_t r, n, hold;
   link_t lr, ln;
   logic take, run, tick, test, any, clr1, clr2, tree;
   logic [6:0] set1;
   logic [4:0] set2;
   logic [7:0] k;
   logic [1:0] div;
   logic link_idle;

   function automatic logic in_blk(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input logic [7:0] cnt);
      in_blk = (a >= base) && (a < base + cnt);
   endfunction

   function automatic main_t reset_state();
      main_t s;
      s = '0;
      s.tst_s = 2'h3;
      s.bti_s = 2'h3;
      s.cfg = hwmon_pkg::CFG_RST;
      s.fandiv = hwmon_pkg::FANDIV_RST;
      s.temp_lim = hwmon_pkg::TEMP_LIM_RST;
      for (int i = 0; i < hwmon_pkg::NUM_VIN; i++) begin
         s.lim_hi[i] = hwmon_pkg::LIM_HI_RST;
         s.lim_lo[i] = hwmon_pkg::LIM_LO_RST;
      end
      for (int i = 0; i < hwmon_pkg::NUM_FAN; i++) begin
         s.fan_lim[i] = hwmon_pkg::FAN_LIM_RST;
      end
      s.int_oe_n = 1'b1;
      s.pwr_oe_n = 1'b1;
      s.ci_oe_n = 1'b1;
      s.ros_oe_n = 1'b1;
      s.a0_oe_n = 1'b1;
      reset_state = s;
   endfunction

   function automatic logic [7:0] rd_mux(input main_t s,
                                         input logic [7:0] a);
      logic [7:0] i;
      i = 8'h00;
      rd_mux = 8'h00;
      if (a == hwmon_pkg::ADDR_CFG) begin
         rd_mux = s.cfg;
      end else if (a == hwmon_pkg::ADDR_ST1) begin
         rd_mux = {1'b0, s.st1};
      end else if (a == hwmon_pkg::ADDR_ST2) begin
         rd_mux = {3'h0, s.st2};
      end else if (a == hwmon_pkg::ADDR_FANDIV) begin
         rd_mux = s.fandiv;
      end else if (a == hwmon_pkg::ADDR_TEMP_LIM) begin
         rd_mux = s.temp_lim;
      end else if (in_blk(a, hwmon_pkg::ADDR_LIM_BASE,
                          hwmon_pkg::LIM_CNT)) begin
         i = a - hwmon_pkg::ADDR_LIM_BASE;
         rd_mux = i[0] ? s.lim_lo[i[3:1]] : s.lim_hi[i[3:1]];
      end else if (in_blk(a, hwmon_pkg::ADDR_VAL_BASE,
                          hwmon_pkg::VAL_CNT)) begin
         i = a - hwmon_pkg::ADDR_VAL_BASE;
         rd_mux = s.val[i[2:0]];
      end else if (in_blk(a, hwmon_pkg::ADDR_FCNT_BASE,
                          hwmon_pkg::FAN_REG_CNT)) begin
         i = a - hwmon_pkg::ADDR_FCNT_BASE;
         rd_mux = s.fan_cnt[i[0]];
      end else if (in_blk(a, hwmon_pkg::ADDR_FLIM_BASE,
                          hwmon_pkg::FAN_REG_CNT)) begin
         i = a - hwmon_pkg::ADDR_FLIM_BASE;
         rd_mux = s.fan_lim[i[0]];
      end
   endfunction

   // main domain
   always_comb begin
      n = r;
      hold = r;
      k = 8'h00;
      div = 2'h0;
      set1 = 7'h00;
      set2 = 5'h00;
      clr1 = 1'b0;
      clr2 = 1'b0;
      tree = 1'b1;
      n.tst_s = {r.tst_s[0], CONNECTIVITY_TEST_IN_N_I};
      n.bti_s = {r.bti_s[0], BOARD_TEMP_ALERT_IN_N_I};
      n.ci_s = {r.ci_s[0], CASE_OPEN_LINE_I};
      n.fan_s = {r.fan_s[0], FAN_TACH_INPUTS_I};
      n.addr_s = {r.addr_s[0], ADDR_UPPER_PINS_I, ADDR_LSB_TEST_OUT_I};
      n.req_s = {r.req_s[0], lr.req};
      n.rdata = 8'h00;
      test = !r.tst_s[1]; // see R12
      run = r.cfg[hwmon_pkg::CFG_START]; // see R18
      take = r.req_s[1] != r.req_seen;
      n.req_seen = r.req_s[1];
      // codes are 8-bit, 10 mV per step over 2.56 V
      if (take && run) begin // see R3
         n.val[lr.ch] = lr.data;
         if (lr.ch == hwmon_pkg::TEMP_CH) begin
            if (lr.data > r.temp_lim) begin
               set2[hwmon_pkg::ST2_TEMP] = 1'b1; // see R1
            end
         end else if (lr.data > r.lim_hi[lr.ch] ||
                      lr.data < r.lim_lo[lr.ch]) begin
            set1[lr.ch] = 1'b1; // see R2
         end
      end
      // fan period in base ticks, divided by 2^div
      tick = r.base_cnt == hwmon_pkg::FAN_TICK_LAST;
      if (run) begin
         n.base_cnt = tick ? 16'h0000 : r.base_cnt + 16'h0001;
      end
      for (int f = 0; f < hwmon_pkg::NUM_FAN; f++) begin
         div = r.fandiv[f * hwmon_pkg::FD_DIV_W +: hwmon_pkg::FD_DIV_W];
         n.fan_prev[f] = r.fan_s[1][f];
         if (run) begin // see R4
            if (tick) begin
               if (r.pre_cnt[f] >= 8'((8'h01 << div) - 8'h01)) begin
                  n.pre_cnt[f] = 8'h00;
                  if (r.fan_acc[f] != hwmon_pkg::COUNT_SAT) begin
                     n.fan_acc[f] = r.fan_acc[f] + 8'h01;
                  end
               end else begin
                  n.pre_cnt[f] = r.pre_cnt[f] + 8'h01;
               end
            end
            if (r.fan_s[1][f] && !r.fan_prev[f]) begin
               n.fan_cnt[f] = r.fan_acc[f];
               n.fan_acc[f] = 8'h00;
               n.pre_cnt[f] = 8'h00;
               if (r.fan_acc[f] > r.fan_lim[f]) begin
                  set2[hwmon_pkg::ST2_FAN0 + f] = 1'b1; // see R1
               end
            end else if (r.fan_acc[f] == hwmon_pkg::COUNT_SAT) begin
               set2[hwmon_pkg::ST2_FAN0 + f] = 1'b1;
            end
         end
      end
      if (!r.bti_s[1]) begin
         set2[hwmon_pkg::ST2_BTI] = 1'b1; // see R16
      end
      if (r.ci_s[1]) begin
         set2[hwmon_pkg::ST2_CASE] = 1'b1; // see R5
      end
      if (r.ci_clr) begin
         if (r.ci_cnt == CLR_PULSE_CYC - 20'h00001) begin
            n.ci_clr = 1'b0;
         end else begin
            n.ci_cnt = r.ci_cnt + 20'h00001;
         end
      end
      if (r.rst_act) begin
         if (r.rst_cnt == RST_PULSE_CYC - 20'h00001) begin
            n.rst_act = 1'b0;
         end else begin
            n.rst_cnt = r.rst_cnt + 20'h00001;
         end
      end
      if (REG_WR_I) begin
         if (REG_ADDR_I == hwmon_pkg::ADDR_CFG) begin
            n.cfg = REG_WDATA_I;
            if (REG_WDATA_I[hwmon_pkg::CFG_INT_MODE] && !r.ci_clr) begin
               n.ci_clr = 1'b1; // see R6
               n.ci_cnt = 20'h00000;
            end
            if (REG_WDATA_I[hwmon_pkg::CFG_MRST_EN] &&
                r.fandiv[hwmon_pkg::FD_MRST_EN] && !r.rst_act) begin
               n.rst_act = 1'b1; // see R10
               n.rst_cnt = 20'h00000;
            end
         end else if (REG_ADDR_I == hwmon_pkg::ADDR_FANDIV) begin
            n.fandiv = REG_WDATA_I;
         end else if (REG_ADDR_I == hwmon_pkg::ADDR_TEMP_LIM) begin
            n.temp_lim = REG_WDATA_I;
         end else if (in_blk(REG_ADDR_I, hwmon_pkg::ADDR_LIM_BASE,
                             hwmon_pkg::LIM_CNT)) begin
            k = REG_ADDR_I - hwmon_pkg::ADDR_LIM_BASE;
            if (k[0]) begin
               n.lim_lo[k[3:1]] = REG_WDATA_I;
            end else begin
               n.lim_hi[k[3:1]] = REG_WDATA_I;
            end
         end else if (in_blk(REG_ADDR_I, hwmon_pkg::ADDR_FLIM_BASE,
                             hwmon_pkg::FAN_REG_CNT)) begin
            k = REG_ADDR_I - hwmon_pkg::ADDR_FLIM_BASE;
            n.fan_lim[k[0]] = REG_WDATA_I;
         end
      end
      if (REG_RD_I) begin
         n.rdata = rd_mux(r, REG_ADDR_I);
         clr1 = REG_ADDR_I == hwmon_pkg::ADDR_ST1;
         clr2 = REG_ADDR_I == hwmon_pkg::ADDR_ST2;
      end
      // a new event beats a read clear
      n.st1 = (clr1 ? 7'h00 : r.st1) | set1; // see R19
      n.st2 = (clr2 ? 5'h00 : r.st2) | set2; // see R19
      any = (|n.st1) || (|n.st2);
      n.int_o = 1'b0;
      n.int_oe_n = 1'b1;
      if (n.cfg[hwmon_pkg::CFG_INT_EN]) begin // see R8
         n.int_oe_n = !any; // see R1
         n.int_o = n.cfg[hwmon_pkg::CFG_INT_MODE] && any; // see R7
      end
      n.pwr_oe_n = !n.cfg[hwmon_pkg::CFG_PWR_SW]; // see R17
      n.ci_oe_n = !n.ci_clr; // see R6
      n.ros_oe_n = !(n.rst_act || // see R9
                     (n.fandiv[hwmon_pkg::FD_OS_EN] &&
                      n.val[hwmon_pkg::TEMP_CH] > n.temp_lim)); // see R11
      n.dev_addr = r.addr_s[1]; // see R15
      n.a0_o = 1'b0;
      n.a0_oe_n = 1'b1;
      if (test) begin
         // tree over synchronised tach, upper address, alert and case inputs
         for (int b = 0; b < hwmon_pkg::NUM_FAN; b++) begin
            tree = !(tree && r.fan_s[1][b]);
            tree = !(tree && r.addr_s[1][b + 1]);
         end
         tree = !(tree && r.bti_s[1]);
         tree = !(tree && r.ci_s[1]);
         hold = n;
         n = reset_state(); // see R13
         n.tst_s = hold.tst_s;
         n.bti_s = hold.bti_s;
         n.ci_s = hold.ci_s;
         n.fan_s = hold.fan_s;
         n.addr_s = hold.addr_s;
         n.req_s = hold.req_s;
         n.req_seen = hold.req_seen;
         n.fan_prev = hold.fan_prev;
         n.a0_o = tree; // see R14
         n.a0_oe_n = 1'b0; // see R14
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         r <= reset_state();
      end else begin
         r <= n;
      end
   end

   // link domain: sample words cross by toggle handshake
   assign link_idle = (lr.req == lr.ack_s[1]) && !lr.rst_s[1];

   always_comb begin
      ln = lr;
      ln.rst_s = {lr.rst_s[0], SYS_RST_I};
      ln.ack_s = {lr.ack_s[0], r.req_seen};
      if (lr.rst_s[1]) begin
         ln.req = 1'b0;
         ln.ch = 3'h0;
         ln.data = 8'h00;
      end else if (SAMPLE_VALID_I && link_idle) begin
         ln.req = !lr.req;
         ln.ch = SAMPLE_CH_I;
         ln.data = SAMPLE_DATA_I;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      lr <= ln;
   end

   assign SAMPLE_READY_O = link_idle;
   assign REG_RDATA_O = r.rdata;
   assign MONITOR_ACTIVE_O = r.cfg[hwmon_pkg::CFG_START];
   assign CASE_OPEN_LINE_O = 1'b0;
   assign CASE_OPEN_LINE_OE_N_O = r.ci_oe_n;
   assign INT_O = r.int_o;
   assign INT_OE_N_O = r.int_oe_n;
   assign POWER_SWITCH_OUT_O = 1'b0;
   assign POWER_SWITCH_OUT_OE_N_O = r.pwr_oe_n;
   assign MASTER_RESET_OR_OVERTEMP_OUT_O = 1'b0;
   assign MASTER_RESET_OR_OVERTEMP_OUT_OE_N_O = r.ros_oe_n;
   assign ADDR_LSB_TEST_OUT_O = r.a0_o;
   assign ADDR_LSB_TEST_OUT_OE_N_O = r.a0_oe_n;
   assign DEV_ADDR_LOW_O = r.dev_addr;

   // low-time counters for the pulse checks
   logic [19:0] ci_low_cnt, ros_low_cnt;
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I || CASE_OPEN_LINE_OE_N_O) begin
         ci_low_cnt <= 20'h00000;
      end else begin
         ci_low_cnt <= ci_low_cnt + 20'h00001;
      end
      if (SYS_RST_I || MASTER_RESET_OR_OVERTEMP_OUT_OE_N_O) begin
         ros_low_cnt <= 20'h00000;
      end else begin
         ros_low_cnt <= ros_low_cnt + 20'h00001;
      end
   end

   a_int_off: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R8
      !r.cfg[hwmon_pkg::CFG_INT_EN] |-> INT_OE_N_O && !INT_O)
      else $error("interrupt pin driven while disabled");
   a_int_drain: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R1
      r.cfg[hwmon_pkg::CFG_INT_EN] && !r.cfg[hwmon_pkg::CFG_INT_MODE] &&
      (|r.st1) |-> !INT_OE_N_O && !INT_O)
      else $error("open-drain interrupt not asserted");
   a_int_source: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R7
      r.cfg[hwmon_pkg::CFG_INT_EN] && r.cfg[hwmon_pkg::CFG_INT_MODE] &&
      (|r.st2) |-> !INT_OE_N_O && INT_O)
      else $error("open-source interrupt not asserted");
   a_volt_flag: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R2
      take && run && !test && lr.ch == 3'h2 && lr.data > r.lim_hi[2]
      |=> r.st1[2])
      else $error("voltage excursion not flagged");
   a_flag_hold: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R19
      r.st2[hwmon_pkg::ST2_BTI] && !REG_RD_I && !test
      |=> r.st2[hwmon_pkg::ST2_BTI])
      else $error("status flag lost without a read");
   a_ci_pulse: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R6
      $rose(CASE_OPEN_LINE_OE_N_O) && r.tst_s[1]
      |-> ci_low_cnt >= CLR_PULSE_CYC)
      else $error("case line clear pulse too short");
   a_rst_pulse: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R9
      $rose(MASTER_RESET_OR_OVERTEMP_OUT_OE_N_O) && $past(r.rst_act)
      && r.tst_s[1] |-> ros_low_cnt >= RST_PULSE_CYC)
      else $error("master reset pulse too short");
   a_rst_enable: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R10
      $rose(r.rst_act) |-> $past(r.fandiv[hwmon_pkg::FD_MRST_EN]) &&
      $past(REG_WDATA_I[hwmon_pkg::CFG_MRST_EN]) && $past(REG_WR_I))
      else $error("master reset without enables");
   a_pwr_switch: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R17
      REG_WR_I && REG_ADDR_I == hwmon_pkg::ADDR_CFG && !test &&
      REG_WDATA_I[hwmon_pkg::CFG_PWR_SW] |=> !POWER_SWITCH_OUT_OE_N_O)
      else $error("power switch not driven");
   a_test_reset: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R13
      test |=> r.cfg == hwmon_pkg::CFG_RST && r.st1 == 7'h00)
      else $error("test mode did not reset state");
   a_test_pin: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I) // see R14
      test |=> !ADDR_LSB_TEST_OUT_OE_N_O ##1 $stable(r.a0_oe_n) || !test)
      else $error("address pin not driving tree result");

endmodule

// [hdl/hwmon_pkg.sv]
package hwmon_pkg;

   // timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned PULSE_MIN_MS = 10;
   localparam logic [19:0] PULSE_MIN_CYC = 20'(PULSE_MIN_MS * CLK_MHZ * 1000);
   localparam logic [15:0] FAN_BASE_CYC = 16'h0FA0;
   localparam logic [15:0] FAN_TICK_LAST = FAN_BASE_CYC - 16'h0001;

   // register offsets
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_ST1 = 8'h01;
   localparam logic [7:0] ADDR_ST2 = 8'h02;
   localparam logic [7:0] ADDR_FANDIV = 8'h05;
   localparam logic [7:0] ADDR_TEMP_LIM = 8'h07;
   localparam logic [7:0] ADDR_LIM_BASE = 8'h10;
   localparam logic [7:0] LIM_CNT = 8'h0E;
   localparam logic [7:0] ADDR_VAL_BASE = 8'h20;
   localparam logic [7:0] VAL_CNT = 8'h08;
   localparam logic [7:0] ADDR_FCNT_BASE = 8'h28;
   localparam logic [7:0] ADDR_FLIM_BASE = 8'h2A;
   localparam logic [7:0] FAN_REG_CNT = 8'h02;

   // configuration fields
   localparam int unsigned CFG_START = 0;
   localparam int unsigned CFG_INT_EN = 1;
   localparam int unsigned CFG_PWR_SW = 3;
   localparam int unsigned CFG_MRST_EN = 4;
   localparam int unsigned CFG_INT_MODE = 5;

   // fan divisor fields
   localparam int unsigned FD_DIV_W = 2;
   localparam int unsigned FD_OS_EN = 6;
   localparam int unsigned FD_MRST_EN = 7;

   // second status fields
   localparam int unsigned ST2_TEMP = 0;
   localparam int unsigned ST2_BTI = 1;
   localparam int unsigned ST2_FAN0 = 2;
   localparam int unsigned ST2_CASE = 4;

   // sizes and channels
   localparam int unsigned NUM_VIN = 7;
   localparam int unsigned NUM_FAN = 2;
   localparam logic [2:0] TEMP_CH = 3'h7;

   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] FANDIV_RST = 8'h00;
   localparam logic [7:0] LIM_HI_RST = 8'hFF;
   localparam logic [7:0] LIM_LO_RST = 8'h00;
   localparam logic [7:0] TEMP_LIM_RST = 8'h7F;
   localparam logic [7:0] FAN_LIM_RST = 8'hFF;
   localparam logic [7:0] COUNT_SAT = 8'hFF;

endpackage
